//--- pkg/unp_pkg.sv
package unp_pkg;
    // Clock rate in MHz
    localparam int unsigned CLK_MHZ         = 250;

    // Bus condition times
    localparam int unsigned SD3_TIME_US     = 3000;
    localparam int unsigned SD5_TIME_US     = 5000;
    localparam int unsigned K_TIME_US       = 1000;
    localparam int unsigned RST_DET_TIME_NS = 2500;

    // Least times round up to whole cycles
    localparam int unsigned SD3_CYCLES      = SD3_TIME_US * CLK_MHZ;
    localparam int unsigned SD5_CYCLES      = SD5_TIME_US * CLK_MHZ;
    localparam int unsigned K_CYCLES        = K_TIME_US * CLK_MHZ;
    localparam int unsigned RST_DET_CYCLES  = (RST_DET_TIME_NS * CLK_MHZ + 999) / 1000;

    // Register byte offsets
    localparam logic [7:0]  OFS_NODE_STATE  = 8'h00;
    localparam logic [7:0]  OFS_ALT_EVENT   = 8'h04;
    localparam logic [7:0]  OFS_EVENT_MASK  = 8'h08;
    localparam int unsigned DEC_BITS        = 8;

    // Alternate event register bits
    localparam int unsigned EV_W            = 6;
    localparam int unsigned EV_SD3          = 0;
    localparam int unsigned EV_SD5          = 1;
    localparam int unsigned EV_RESET        = 2;
    localparam int unsigned EV_RESUME       = 3;
    localparam int unsigned EV_EOP          = 4;
    localparam int unsigned EV_WAKE         = 5;
    localparam logic [EV_W-1:0] EV_RST_VAL  = 6'h00;

    // Node state field codes
    localparam logic [1:0]  NS_RESET        = 2'h0;
    localparam logic [1:0]  NS_RESUME       = 2'h1;
    localparam logic [1:0]  NS_OPER         = 2'h2;
    localparam logic [1:0]  NS_SUSP         = 2'h3;

    // AHB-Lite codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic        HRESP_OKAY      = 1'h0;

    typedef enum logic [3:0] {
        UNP_HELD_IN_RESET_STATE        = 4'h1,
        UNP_NORMAL_OPERATING_STATE     = 4'h2,
        UNP_LOW_POWER_SUSPENDED_STATE  = 4'h4,
        UNP_WAKING_STATE               = 4'h8
    } unp_state_t;
endpackage : unp_pkg

//--- pkg/unp_timer_if.sv
interface unp_timer_if;
    logic run;
    logic hit;
    modport owner (output run, input hit);
    modport timer (input run, output hit);
endinterface : unp_timer_if

//--- rtl/unp_cond_timer.sv
module unp_cond_timer #(
    parameter int unsigned COUNT = 16
) (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       ce,
    unp_timer_if.timer     tif
);
    localparam int unsigned W = $clog2(COUNT + 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // Count cycles of a steady condition, saturate once reached
    assign next_cnt = !tif.run ? '0 :
                      (cnt == W'(COUNT)) ? cnt : cnt + 1'b1;
    // One pulse when the condition has held COUNT cycles
    assign tif.hit  = ce && tif.run && (cnt == W'(COUNT - 1));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            cnt <= '0;
        else if (ce)
            cnt <= next_cnt;
    end
endmodule : unp_cond_timer

//--- rtl/unp_node_ctrl.sv
// Summary of operation
// [RULE_01] Node is always in exactly one of reset, operating, suspended, waking.
// [RULE_02] Suspend, resume, reset conditions latch event flags; enabled flags interrupt.
// [RULE_03] Three milliseconds without bus activity sets the suspend-detect flag.
// [RULE_04] Firmware places the node in suspend after seeing suspend-detect.
// [RULE_05] Suspended node puts transceiver in low power, keeps registers intact.
// [RULE_06] Suspend ends by firmware wake-up or after bus resume signalling detected.
// [RULE_07] Firmware starts remote wake-up only if host enabled it.
// [RULE_08] Firmware writes node state for wake-up after five milliseconds idle.
// [RULE_09] Waking node drives constant K for at least one millisecond.
// [RULE_10] Host continues resume twenty milliseconds then sends end-of-packet.
// [RULE_11] Firmware moves node to operating so host end-of-packet is seen.
// [RULE_12] Firmware retries wake-up if no end-of-packet within 100 ms.
// [RULE_13] Resume or reset seen while suspended can interrupt the controller.
// [RULE_14] Node answers tokens within ten milliseconds after wake-up or reset.
// [RULE_15] Node state changes only on firmware writes to the state field.
// [RULE_16] Field 00 reset, 11 suspend, 10 operating, 01 waking.
// [RULE_17] Outside operating state, port registers and endpoint states held reset.
// [RULE_18] Firmware keeps node waking ten milliseconds before operating.
//
// Our own choices: the AHB-Lite slave port and the address map.
module unp_node_ctrl #(
    parameter int unsigned SD3_CYCLES = unp_pkg::SD3_CYCLES,
    parameter int unsigned SD5_CYCLES = unp_pkg::SD5_CYCLES,
    parameter int unsigned K_CYCLES   = unp_pkg::K_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        bus_active,
    input  wire logic        line_se0,
    input  wire logic        line_k,
    input  wire logic        eop_det,
    input  wire logic        local_wake,
    output logic             drive_k,
    output logic             xcvr_low_power,
    output logic             ep_reset,
    output logic             irq
);
    unp_pkg::unp_state_t state;
    unp_pkg::unp_state_t next_state;

    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [unp_pkg::EV_W-1:0] alternate_event_register;
    logic [unp_pkg::EV_W-1:0] next_alt;
    logic [unp_pkg::EV_W-1:0] ev_set;
    logic [unp_pkg::EV_W-1:0] ev_clr;
    logic [unp_pkg::EV_W-1:0] ev_mask;
    logic [1:0]             node_state_field;
    logic                   line_k_q;
    logic                   k_done;
    logic [31:0]            next_rdata;

    unp_timer_if sd3_tif ();
    unp_timer_if sd5_tif ();
    unp_timer_if rst_tif ();
    unp_timer_if k_tif ();

    // Bus slave decode
    wire addr_ph  = ce && hsel && hready && (htrans == unp_pkg::HTRANS_NONSEQ);
    wire data_ph  = ce && wr_pend;
    wire wr_ns    = data_ph && (wr_addr == unp_pkg::OFS_NODE_STATE);
    wire wr_ev    = data_ph && (wr_addr == unp_pkg::OFS_ALT_EVENT);
    wire wr_mask  = data_ph && (wr_addr == unp_pkg::OFS_EVENT_MASK);
    wire [7:0] ra = haddr[unp_pkg::DEC_BITS-1:0];
    wire [1:0] new_field = hwdata[1:0];

    assign hreadyout = ce;
    assign hresp     = unp_pkg::HRESP_OKAY;

    wire is_oper   = (state == unp_pkg::UNP_NORMAL_OPERATING_STATE);
    wire is_susp   = (state == unp_pkg::UNP_LOW_POWER_SUSPENDED_STATE);
    wire is_resume = (state == unp_pkg::UNP_WAKING_STATE);

    // Condition timers
    assign sd3_tif.run = !bus_active;
    assign sd5_tif.run = !bus_active;
    assign rst_tif.run = line_se0;
    assign k_tif.run   = is_resume;

    unp_cond_timer #(.COUNT(SD3_CYCLES)) u_sd3 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .tif     (sd3_tif.timer)
    );
    unp_cond_timer #(.COUNT(SD5_CYCLES)) u_sd5 (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .tif     (sd5_tif.timer)
    );
    unp_cond_timer #(.COUNT(unp_pkg::RST_DET_CYCLES)) u_rst (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .tif     (rst_tif.timer)
    );
    unp_cond_timer #(.COUNT(K_CYCLES)) u_k (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .tif     (k_tif.timer)
    );

    // Event sources
    wire resume_seen = ce && is_susp && line_k && !line_k_q;        // see [RULE_13]
    always_comb begin
        ev_set                    = '0;
        ev_set[unp_pkg::EV_SD3]    = sd3_tif.hit;                     // see [RULE_03]
        ev_set[unp_pkg::EV_SD5]    = sd5_tif.hit;
        ev_set[unp_pkg::EV_RESET]  = rst_tif.hit;                     // see [RULE_13]
        ev_set[unp_pkg::EV_RESUME] = resume_seen;                     // see [RULE_06]
        ev_set[unp_pkg::EV_EOP]    = ce && is_oper && eop_det;
        ev_set[unp_pkg::EV_WAKE]   = ce && local_wake;
    end

    // Write one to clear; a new event wins over the clear
    assign ev_clr   = wr_ev ? hwdata[unp_pkg::EV_W-1:0] : '0;
    assign next_alt = (alternate_event_register & ~ev_clr) | ev_set; // see [RULE_02]
    assign irq      = |(alternate_event_register & ev_mask);          // see [RULE_02]

    // Firmware alone steers the node state
    always_comb begin
        next_state = state;
        if (wr_ns) begin                                              // see [RULE_15]
            unique case (new_field)                                   // see [RULE_16]
                unp_pkg::NS_RESET:  next_state = unp_pkg::UNP_HELD_IN_RESET_STATE;
                unp_pkg::NS_RESUME: next_state = unp_pkg::UNP_WAKING_STATE;  // see [RULE_06]
                unp_pkg::NS_OPER:   next_state = unp_pkg::UNP_NORMAL_OPERATING_STATE;
                unp_pkg::NS_SUSP:   next_state = unp_pkg::UNP_LOW_POWER_SUSPENDED_STATE;
            endcase
        end
    end

    always_comb begin
        unique case (state)
            unp_pkg::UNP_HELD_IN_RESET_STATE:       node_state_field = unp_pkg::NS_RESET;
            unp_pkg::UNP_NORMAL_OPERATING_STATE:    node_state_field = unp_pkg::NS_OPER;
            unp_pkg::UNP_LOW_POWER_SUSPENDED_STATE: node_state_field = unp_pkg::NS_SUSP;
            unp_pkg::UNP_WAKING_STATE:              node_state_field = unp_pkg::NS_RESUME;
            default:                                node_state_field = unp_pkg::NS_RESET;
        endcase
    end

    // Read mux, sampled in the address phase
    always_comb begin
        next_rdata = '0;
        if (ra == unp_pkg::OFS_NODE_STATE)
            next_rdata[1:0] = node_state_field;
        else if (ra == unp_pkg::OFS_ALT_EVENT)
            next_rdata[unp_pkg::EV_W-1:0] = alternate_event_register;
        else if (ra == unp_pkg::OFS_EVENT_MASK)
            next_rdata[unp_pkg::EV_W-1:0] = ev_mask;
    end

    // Line outputs
    assign drive_k        = is_resume && !k_done;                     // see [RULE_09]
    assign xcvr_low_power = is_susp;                                  // see [RULE_05]
    assign ep_reset       = !is_oper;                                 // see [RULE_17] [RULE_14]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata  <= '0;
        end else if (ce) begin
            wr_pend <= addr_ph && hwrite;
            wr_addr <= ra;
            if (addr_ph && !hwrite)
                hrdata <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= unp_pkg::UNP_HELD_IN_RESET_STATE;                // see [RULE_01]
            alternate_event_register <= unp_pkg::EV_RST_VAL;
            ev_mask  <= '0;
            line_k_q <= 1'b0;
            k_done   <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            alternate_event_register <= next_alt;
            if (wr_mask)
                ev_mask <= hwdata[unp_pkg::EV_W-1:0];
            line_k_q <= line_k;
            k_done   <= is_resume && (k_done || k_tif.hit);          // see [RULE_09]
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence ns_write_s(logic [1:0] code);
        wr_ns && (new_field == code);
    endsequence

    sequence susp_entered_s;
        ##1 (state == unp_pkg::UNP_LOW_POWER_SUSPENDED_STATE);
    endsequence

    one_state_a: assert property ($onehot(state))                     // see [RULE_01]
        else $error("node state not one-hot");

    irq_raise_a: assert property ((|(ev_set & ev_mask)) && !wr_mask |=> irq) // see [RULE_02]
        else $error("enabled event did not raise interrupt");

    sd3_flag_a: assert property (sd3_tif.hit |=>                      // see [RULE_03]
        alternate_event_register[unp_pkg::EV_SD3])
        else $error("suspend detect flag not set");

    low_power_a: assert property (ns_write_s(unp_pkg::NS_SUSP) |->    // see [RULE_05]
        susp_entered_s ##0 (xcvr_low_power && $stable(ev_mask)))
        else $error("suspend entry not low power");

    k_start_a: assert property ((wr_ns && new_field == unp_pkg::NS_RESUME
        && !is_resume) |=> drive_k [*2])                              // see [RULE_09]
        else $error("K not driven on wake");

    k_hold_a: assert property ((is_resume && !k_tif.hit && drive_k && ce
        && !wr_ns) |=> drive_k)                                       // see [RULE_09]
        else $error("K dropped early");

    resume_flag_a: assert property (resume_seen |=>                   // see [RULE_13]
        alternate_event_register[unp_pkg::EV_RESUME])
        else $error("resume not flagged");

    fw_only_a: assert property ((state != $past(state)) |->           // see [RULE_15]
        $past(wr_ns))
        else $error("state changed without write");

    code_map_a: assert property (ns_write_s(unp_pkg::NS_OPER) |=>     // see [RULE_16]
        is_oper && !ep_reset)
        else $error("operating code mismatch");

    ep_hold_a: assert property (!is_oper |-> ep_reset)                // see [RULE_17]
        else $error("endpoints not held in reset");
endmodule : unp_node_ctrl

//--- verification/unp_host_model.sv
module unp_host_model (
    input  wire logic ref_clk,
    output logic      bus_active,
    output logic      line_se0,
    output logic      line_k,
    output logic      eop_det
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_active = 1'h1;
        line_se0   = 1'h0;
        line_k     = 1'h0;
        eop_det    = 1'h0;
    end

    // Holds one line condition for n cycles, then normal traffic returns
    task automatic hold(input logic act, input logic se0, input logic k, input int n);
        @(posedge ref_clk);
        bus_active <= act;
        line_se0   <= se0;
        line_k     <= k;
        repeat (n) @(posedge ref_clk);
        bus_active <= 1'h1;
        line_se0   <= 1'h0;
        line_k     <= 1'h0;
    endtask : hold

    // Host closes the resume with a single end-of-packet pulse
    task automatic send_eop();
        @(posedge ref_clk);
        eop_det <= 1'h1;
        @(posedge ref_clk);
        eop_det <= 1'h0;
    endtask : send_eop
endmodule : unp_host_model

//--- verification/usb_node_power_state_control_test.sv
module usb_node_power_state_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned SD3 = 30;
    localparam int unsigned SD5 = 50;
    localparam int unsigned KC  = 10;

    logic        ref_clk;
    logic        rstn;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        bus_active;
    logic        line_se0;
    logic        line_k;
    logic        eop_det;
    logic        local_wake;
    logic        drive_k;
    logic        xcvr_low_power;
    logic        ep_reset;
    logic        irq;
    int          n_fail;
    int          checks_done;
    int          cycles;
    logic [31:0] rd;

    unp_node_ctrl #(.SD3_CYCLES(SD3), .SD5_CYCLES(SD5), .K_CYCLES(KC)) i_unp_node_ctrl (
        .ref_clk(ref_clk), .rstn(rstn), .ce(1'h1), .hsel(1'h1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .bus_active(bus_active), .line_se0(line_se0), .line_k(line_k),
        .eop_det(eop_det), .local_wake(local_wake), .drive_k(drive_k),
        .xcvr_low_power(xcvr_low_power), .ep_reset(ep_reset), .irq(irq));

    unp_host_model i_unp_host_model (
        .ref_clk(ref_clk), .bus_active(bus_active), .line_se0(line_se0),
        .line_k(line_k), .eop_det(eop_det));

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= unp_pkg::HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, unp_pkg::HRESP_OKAY});
        #1;
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic t_reset_vals();
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESET});
        rd_chk(unp_pkg::OFS_EVENT_MASK, 32'h0);
        rd_chk(8'hFC, 32'h0);
        chk({ep_reset, drive_k, xcvr_low_power, irq}, 32'h8);
    endtask : t_reset_vals

    task automatic t_idle();
        ahb(1'h1, unp_pkg::OFS_EVENT_MASK, 32'h1);
        ahb(1'h1, unp_pkg::OFS_ALT_EVENT, 32'h3F);
        i_unp_host_model.hold(1'h0, 1'h0, 1'h0, SD3 + 8);
        chk({31'h0, irq}, 32'h1);
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h1);
        i_unp_host_model.hold(1'h0, 1'h0, 1'h0, SD5 + 8);
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h3);
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESET});
        ahb(1'h1, unp_pkg::OFS_ALT_EVENT, 32'h3F);
        chk({31'h0, irq}, 32'h0);
    endtask : t_idle

    task automatic t_suspend_resume();
        ahb(1'h1, unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_SUSP});
        chk({ep_reset, xcvr_low_power, drive_k}, 32'h6);
        rd_chk(unp_pkg::OFS_EVENT_MASK, 32'h1);
        ahb(1'h1, unp_pkg::OFS_EVENT_MASK, 32'h8);
        i_unp_host_model.hold(1'h1, 1'h0, 1'h1, 5);
        chk({31'h0, irq}, 32'h1);
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h8);
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_SUSP});
        ahb(1'h1, unp_pkg::OFS_ALT_EVENT, 32'h8);
    endtask : t_suspend_resume

    task automatic t_remote_wake();
        @(posedge ref_clk);
        local_wake <= 1'h1;
        @(posedge ref_clk);
        local_wake <= 1'h0;
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h20);
        ahb(1'h1, unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESUME});
        chk({xcvr_low_power, drive_k, ep_reset}, 32'h3);
        repeat (KC - 3) @(posedge ref_clk);
        #1 chk({31'h0, drive_k}, 32'h1);
        repeat (6) @(posedge ref_clk);
        #1 chk({31'h0, drive_k}, 32'h0);
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESUME});
        ahb(1'h1, unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_OPER});
        chk({ep_reset, xcvr_low_power, drive_k}, 32'h0);
        i_unp_host_model.send_eop();
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h30);
        ahb(1'h1, unp_pkg::OFS_ALT_EVENT, 32'h30);
    endtask : t_remote_wake

    task automatic t_bus_reset();
        i_unp_host_model.hold(1'h1, 1'h1, 1'h0, unp_pkg::RST_DET_CYCLES + 5);
        rd_chk(unp_pkg::OFS_ALT_EVENT, 32'h4);
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_OPER});
        ahb(1'h1, unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESET});
        chk({ep_reset, xcvr_low_power, drive_k}, 32'h4);
        rd_chk(unp_pkg::OFS_NODE_STATE, {30'h0, unp_pkg::NS_RESET});
    endtask : t_bus_reset

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        rstn       = 1'h0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'h0;
        hwdata     = 32'h0;
        local_wake = 1'h0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'h1;
        t_reset_vals();
        t_idle();
        t_suspend_resume();
        t_remote_wake();
        t_bus_reset();
        end_sim();
    end
endmodule : usb_node_power_state_control_test
